/* fsk_iface_pkg.sv */
// constants, types and mode encodings shared by the fsk serial interface files
// assumes a single 40 MHz system clock and pin-level control inputs
//
// Functional notes
// - mark frequency gives data 1, space frequency gives data 0.
// - mode 0 drives the demodulated bit stream straight to the data output.
// - mode 1 drops the start bit, keeps eight data bits plus stop bit.
// - a ninth shift pulse presents the stop bit for framing checks.
// - in fsk function ready idles high, low half a bit at word end in mode 0, at shifter load of the word in mode 1.
// - mode 1 first rising shift edge during ready low returns ready high.
// - in tone functions the shared pin carries delayed steering, low on qualified tone.
// - in tone functions, early tone flag high whenever raw detector accepts the tone.
// - guard node above threshold drives steering low; below it re-arms, steering high.
// - carrier output low while fsk present, with hold-off against brief dropouts.
// - demodulated data is suppressed until carrier detect is active.
// - two function selects choose fsk, line tone or handset tone detection.
// - mode 1 with both function selects low powers the block down.
// - selects 11 fsk, 10 handset tone, 01 line tone.
// - mode 0 drives the shift clock pin as a mid-bit strobe.
package fsk_iface_pkg;

	localparam int CLOCK_HZ = 40_000_000;
	localparam int BAUD_RATE = 1200;
	// one bit period in clocks, rounded down
	localparam int BIT_CYCLES = CLOCK_HZ / BAUD_RATE;
	localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
	// carrier hold-off time
	localparam int CARRIER_HOLD_US = 10000;
	localparam int CARRIER_HOLD_CYCLES = CARRIER_HOLD_US * (CLOCK_HZ / 1_000_000);
	// width of the mode 0 mid-bit strobe, least time rounded up
	localparam int STROBE_NS = 2000;
	localparam int CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
	localparam int STROBE_CYCLES = (STROBE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	localparam int WORD_BITS = 9;
	localparam int STOP_INDEX = 8;
	localparam int BUFFER_DEPTH = 2;
	localparam logic START_LEVEL = 1'h0;
	localparam logic MARK_LEVEL = 1'h1;

	typedef enum logic [1:0] {FUNC_OFF, FUNC_LINE_TONE, FUNC_HANDSET_TONE, FUNC_FSK} func_type;
	typedef enum logic [1:0] {DF_IDLE, DF_BITS, DF_PUSH} deframe_type;

endpackage

/* word_link_if.sv */
// valid/ready word path between the deframer, the buffer and the shifter
// assumes all parties share one clock
`timescale 1ns/1ps
`default_nettype none
interface word_link_if #(parameter int WIDTH = 9);
	logic inValid;
	logic inReady;
	logic [WIDTH-1:0] inWord;
	logic outValid;
	logic outReady;
	logic [WIDTH-1:0] outWord;
	modport producer (output inValid, output inWord, input inReady);
	modport buffer (input inValid, input inWord, output inReady,
		output outValid, output outWord, input outReady);
	modport consumer (input outValid, input outWord, output outReady);
endinterface
`default_nettype wire

/* word_buffer.sv */
// small flip-flop fifo on the received word path
// assumes depth is a power of two and one clock domain
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic clock,
	input wire logic rst_n,
	word_link_if.buffer link
);
	import fsk_iface_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_COUNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [PW:0] count_reg, count_next;
	logic doPush, doPop;

	assign link.inReady = (count_reg != DEPTH_COUNT);
	assign link.outValid = (count_reg != '0);
	assign link.outWord = mem_reg[rdPtr_reg];

	always_comb
	begin
		doPush = link.inValid && link.inReady;
		doPop = link.outValid && link.outReady;
		mem_next = mem_reg;
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (doPush)
		begin
			mem_next[wrPtr_reg] = link.inWord;
			wrPtr_next = wrPtr_reg + 1'b1;
		end
		if (doPop)
			rdPtr_next = rdPtr_reg + 1'b1;
		if (doPush && !doPop)
			count_next = count_reg + 1'b1;
		else if (doPop && !doPush)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_reg[i] <= '0;
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			mem_reg <= mem_next;
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
		end
	end

	a_buffer_no_overflow: assert property (@(posedge clock) disable iff (!rst_n)
		count_reg <= DEPTH_COUNT)
		else $error("word buffer count beyond depth");

endmodule // word_buffer
`default_nettype wire

/* fsk_serial_interface_ctrl.sv */
// digital output side of the caller-identity receiver: data, shift clock,
// ready/steering, early tone flag, carrier detect, function and power control
// assumes demodulator and tone detector strobes arrive on the system clock;
// control pins, shift clock pin and guard comparator are asynchronous
`timescale 1ns/1ps
`default_nettype none
module fsk_serial_interface_ctrl #(
	parameter int HALF_BIT = fsk_iface_pkg::HALF_BIT_CYCLES,
	parameter int CARRIER_HOLD = fsk_iface_pkg::CARRIER_HOLD_CYCLES,
	parameter int DEPTH = fsk_iface_pkg::BUFFER_DEPTH
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic iface_select,
	input wire logic function_select_a,
	input wire logic function_select_b,
	input wire logic demodBit,
	input wire logic bitMidStrobe,
	input wire logic carrierRaw,
	input wire logic toneRaw,
	input wire logic guard_time_node,
	input wire logic shift_clock_pin_in,
	output logic shift_clock_pin_out,
	output logic shift_clock_pin_oe,
	output logic dataOut,
	output logic ready_or_steering_n,
	output logic early_tone_flag,
	output logic carrier_present_n,
	output logic handsetInputSelect,
	output logic powerDown
);
	import fsk_iface_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic shiftPrev_reg;
	logic [4:0] s1_reg, s2_reg;
	logic mode1, shiftRise;
	func_type func;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			shiftPrev_reg <= 1'h0;
		end
		else
		begin
			s1_reg <= {guard_time_node, shift_clock_pin_in, function_select_b,
				function_select_a, iface_select};
			s2_reg <= s1_reg;
			shiftPrev_reg <= s2_reg[3];
		end
	end

	assign mode1 = s2_reg[0];
	assign func = func_type'({s2_reg[1], s2_reg[2]});
	assign shiftRise = mode1 && s2_reg[3] && !shiftPrev_reg;
	logic fskOn, toneOn;
	assign fskOn = (func == FUNC_FSK);
	assign toneOn = (func == FUNC_LINE_TONE) || (func == FUNC_HANDSET_TONE);

	//////////////////////////////////////////////////////////////////////////
	// function and power control
	logic pd_reg, pd_next, hs_reg, hs_next, est_reg, est_next, std_reg, std_next;
	always_comb
	begin
		pd_next = mode1 && (func == FUNC_OFF);
		hs_next = (func == FUNC_HANDSET_TONE);
		est_next = toneOn && toneRaw;
		std_next = !(toneOn && s2_reg[4]);
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pd_reg <= 1'h0;
			hs_reg <= 1'h0;
			est_reg <= 1'h0;
			std_reg <= 1'h1;
		end
		else
		begin
			pd_reg <= pd_next;
			hs_reg <= hs_next;
			est_reg <= est_next;
			std_reg <= std_next;
		end
	end
	assign powerDown = pd_reg;
	assign handsetInputSelect = hs_reg;
	assign early_tone_flag = est_reg;

	//////////////////////////////////////////////////////////////////////////
	// carrier detect with hold-off
	logic [$clog2(CARRIER_HOLD+1)-1:0] cdCnt_reg, cdCnt_next;
	logic cd_reg, cd_next;
	always_comb
	begin
		cdCnt_next = cdCnt_reg;
		cd_next = cd_reg;
		if (!fskOn)
		begin
			cdCnt_next = '0;
			cd_next = 1'h0;
		end
		else if (carrierRaw)
		begin
			cdCnt_next = '0;
			cd_next = 1'h1;
		end
		else if (cd_reg)
		begin
			// short dropouts must not end the carrier
			if (cdCnt_reg == $bits(cdCnt_reg)'(CARRIER_HOLD - 1))
			begin
				cd_next = 1'h0;
				cdCnt_next = '0;
			end
			else
				cdCnt_next = cdCnt_reg + 1'b1;
		end
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cdCnt_reg <= '0;
			cd_reg <= 1'h0;
		end
		else
		begin
			cdCnt_reg <= cdCnt_next;
			cd_reg <= cd_next;
		end
	end
	assign carrier_present_n = !cd_reg;

	//////////////////////////////////////////////////////////////////////////
	// deframer: start bit, eight data bits, stop bit
	word_link_if #(.WIDTH(WORD_BITS)) link ();
	deframe_type df_reg, df_next;
	logic [WORD_BITS-1:0] sh_reg, sh_next;
	logic [3:0] bitCnt_reg, bitCnt_next;
	logic wordEnd;
	logic bitIn;
	assign bitIn = demodBit;
	always_comb
	begin
		df_next = df_reg;
		sh_next = sh_reg;
		bitCnt_next = bitCnt_reg;
		wordEnd = 1'h0;
		case (df_reg)
			DF_IDLE:
				if (cd_reg && bitMidStrobe && bitIn == START_LEVEL)
				begin
					df_next = DF_BITS;
					bitCnt_next = '0;
				end
			DF_BITS:
				if (!cd_reg)
					df_next = DF_IDLE;
				else if (bitMidStrobe)
				begin
					sh_next = {bitIn, sh_reg[WORD_BITS-1:1]};
					bitCnt_next = bitCnt_reg + 1'b1;
					if (bitCnt_reg == 4'(STOP_INDEX))
					begin
						wordEnd = 1'h1;
						df_next = mode1 ? DF_PUSH : DF_IDLE;
					end
				end
			DF_PUSH:
				// waits while the buffer is full rather than dropping the word
				if (link.inReady)
					df_next = DF_IDLE;
			default:
				df_next = DF_IDLE;
		endcase
		if (!fskOn)
			df_next = DF_IDLE;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			df_reg <= DF_IDLE;
			sh_reg <= '0;
			bitCnt_reg <= '0;
		end
		else
		begin
			df_reg <= df_next;
			sh_reg <= sh_next;
			bitCnt_reg <= bitCnt_next;
		end
	end
	assign link.inValid = (df_reg == DF_PUSH);
	assign link.inWord = sh_reg;
	word_buffer #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) word_buffer_inst (
		.clock(clock),
		.rst_n(rst_n),
		.link(link.buffer)
	);

	//////////////////////////////////////////////////////////////////////////
	// mode 1 shifter, ready pulse, mode 0 strobe
	logic [WORD_BITS-1:0] out_reg, out_next;
	logic [3:0] shCnt_reg, shCnt_next;
	logic loaded_reg, loaded_next, take;
	logic data_reg, data_next, rdy_reg, rdy_next;
	logic [$clog2(HALF_BIT+1)-1:0] rdyCnt_reg, rdyCnt_next;
	logic [$clog2(STROBE_CYCLES+1)-1:0] stb_reg, stb_next;
	// stop bit stays readable; an unframed read yields only when the buffer is full
	assign take = mode1 && link.outValid && (!loaded_reg || shCnt_reg >= 4'(WORD_BITS)
		|| (shCnt_reg >= 4'(STOP_INDEX) && !link.inReady));
	assign link.outReady = take;
	always_comb
	begin
		out_next = out_reg;
		shCnt_next = shCnt_reg;
		loaded_next = loaded_reg;
		data_next = data_reg;
		rdy_next = rdy_reg;
		rdyCnt_next = rdyCnt_reg;
		stb_next = (stb_reg != '0) ? stb_reg - 1'b1 : stb_reg;
		if (!mode1)
		begin
			loaded_next = 1'h0;
			data_next = cd_reg ? bitIn : MARK_LEVEL;
			if (cd_reg && bitMidStrobe)
				stb_next = $bits(stb_reg)'(STROBE_CYCLES);
		end
		else if (take)
		begin
			out_next = link.outWord;
			shCnt_next = '0;
			loaded_next = 1'h1;
		end
		else if (shiftRise && loaded_reg && shCnt_reg < 4'(WORD_BITS))
		begin
			data_next = out_reg[shCnt_reg];
			shCnt_next = shCnt_reg + 1'b1;
		end
		if (rdy_reg)
		begin
			if (rdyCnt_reg == $bits(rdyCnt_reg)'(HALF_BIT - 1) || (mode1 && shiftRise))
				rdy_next = 1'h0;
			rdyCnt_next = rdyCnt_reg + 1'b1;
		end
		if ((mode1 && take) || (!mode1 && wordEnd))
		begin
			rdy_next = 1'h1;
			rdyCnt_next = '0;
		end
		if (!fskOn)
		begin
			rdy_next = 1'h0;
			loaded_next = 1'h0;
			stb_next = '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_reg <= '0;
			shCnt_reg <= '0;
			loaded_reg <= 1'h0;
			data_reg <= MARK_LEVEL;
			rdy_reg <= 1'h0;
			rdyCnt_reg <= '0;
			stb_reg <= '0;
		end
		else
		begin
			out_reg <= out_next;
			shCnt_reg <= shCnt_next;
			loaded_reg <= loaded_next;
			data_reg <= data_next;
			rdy_reg <= rdy_next;
			rdyCnt_reg <= rdyCnt_next;
			stb_reg <= stb_next;
		end
	end
	assign dataOut = data_reg;
	assign shift_clock_pin_oe = !mode1;
	assign shift_clock_pin_out = (stb_reg != '0);
	assign ready_or_steering_n = toneOn ? std_reg : !rdy_reg;

	//////////////////////////////////////////////////////////////////////////
	// checks
	a_ready_half_bit: assert property (@(posedge clock) disable iff (!rst_n)
		rdy_reg |-> rdyCnt_reg < $bits(rdyCnt_reg)'(HALF_BIT))
		else $error("ready pulse longer than half a bit");
	a_shift_clears_ready: assert property (@(posedge clock) disable iff (!rst_n)
		(fskOn && mode1 && rdy_reg && shiftRise && !take) |=> !rdy_reg)
		else $error("shift edge did not clear ready");
	a_mode0_passthru: assert property (@(posedge clock) disable iff (!rst_n)
		(!mode1 && cd_reg) |=> dataOut == $past(bitIn))
		else $error("mode 0 data not passed through");
	a_gated_no_carrier: assert property (@(posedge clock) disable iff (!rst_n)
		(!mode1 && !cd_reg) |=> dataOut == MARK_LEVEL)
		else $error("data not suppressed without carrier");
	a_steer_follows_guard: assert property (@(posedge clock) disable iff (!rst_n)
		(toneOn && s2_reg[4]) ##1 toneOn |-> !ready_or_steering_n)
		else $error("steering not low with guard high");
	a_early_tone: assert property (@(posedge clock) disable iff (!rst_n)
		(toneOn && toneRaw) |=> early_tone_flag)
		else $error("early tone flag missing");
	a_carrier_on: assert property (@(posedge clock) disable iff (!rst_n)
		(fskOn && carrierRaw) |=> !carrier_present_n)
		else $error("carrier not reported");
	a_power_down: assert property (@(posedge clock) disable iff (!rst_n)
		(mode1 && func == FUNC_OFF) |=> powerDown)
		else $error("power down not entered");
	a_shift_order: assert property (@(posedge clock) disable iff (!rst_n)
		(mode1 && shiftRise && loaded_reg && !take && shCnt_reg < 4'(WORD_BITS))
		|=> dataOut == $past(out_reg[shCnt_reg]))
		else $error("shifted bit out of order");
	a_strobe_mode0: assert property (@(posedge clock) disable iff (!rst_n)
		(!mode1 && fskOn && cd_reg && bitMidStrobe) |=> shift_clock_pin_out [*2])
		else $error("mid-bit strobe missing");
	c_word_mode1: cover property (@(posedge clock) disable iff (!rst_n) take ##1 rdy_reg);
	c_stop_bit: cover property (@(posedge clock) disable iff (!rst_n)
		shiftRise && shCnt_reg == 4'(STOP_INDEX));
	c_buffer_full: cover property (@(posedge clock) disable iff (!rst_n) !link.inReady);
	c_steering: cover property (@(posedge clock) disable iff (!rst_n)
		toneOn && !ready_or_steering_n);
endmodule // fsk_serial_interface_ctrl
`default_nettype wire

/* fsk_iface_unused.sv */
// spare source unit: holds no code
// assumes nothing of its surroundings

/* mcu_reader_model.sv */
// controller model on the far side: drives the shift clock pin and reads data
// assumes the bench calls readWord only while a word is loaded in mode 1
`timescale 1ns/1ps
`default_nettype none
module mcu_reader_model (
	input wire logic dataIn,
	input wire logic pinFromDevice,
	input wire logic pinEnable,
	output logic pinLevel
);
	logic pinDrive = 1'h0;
	// shared pin: the device drives it in mode 0, the controller in mode 1
	assign pinLevel = pinEnable ? pinFromDevice : pinDrive;
	////////////////////////////////////////////////////////////////////////
	// 100 ns pulses every 200 ns, pin stands low between reads
	task automatic readWord(output logic [8:0] word);
		#11;
		for (int i = 0; i < 9; i++)
		begin
			pinDrive = 1'h1;
			#100;
			pinDrive = 1'h0;
			#100;
			// sampled late so the synchronised edge has long settled
			word[i] = dataIn;
		end
	endtask
endmodule // mcu_reader_model
`default_nettype wire

/* tb.sv */
// self-checking bench for the serial interface controller
// assumes shortened half bit and carrier hold counts
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fsk_iface_pkg::*;
	localparam int HALF = 20;
	localparam int HOLD = 50;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic iface_select = 1'h0;
	logic function_select_a = 1'h1;
	logic function_select_b = 1'h1;
	logic demodBit = 1'h1;
	logic bitMidStrobe = 1'h0;
	logic carrierRaw = 1'h0;
	logic toneRaw = 1'h0;
	logic guard_time_node = 1'h0;
	logic shift_clock_pin_in;
	logic shift_clock_pin_out, shift_clock_pin_oe, dataOut, ready_or_steering_n;
	logic early_tone_flag, carrier_present_n, handsetInputSelect, powerDown;
	logic [8:0] word;
	int n;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	always #12.5 clock = ~clock;
	fsk_serial_interface_ctrl #(.HALF_BIT(HALF), .CARRIER_HOLD(HOLD), .DEPTH(2))
		fsk_serial_interface_ctrl_inst (.clock(clock), .rst_n(rst_n),
		.iface_select(iface_select), .function_select_a(function_select_a),
		.function_select_b(function_select_b), .demodBit(demodBit),
		.bitMidStrobe(bitMidStrobe), .carrierRaw(carrierRaw), .toneRaw(toneRaw),
		.guard_time_node(guard_time_node), .shift_clock_pin_in(shift_clock_pin_in),
		.shift_clock_pin_out(shift_clock_pin_out), .shift_clock_pin_oe(shift_clock_pin_oe),
		.dataOut(dataOut), .ready_or_steering_n(ready_or_steering_n),
		.early_tone_flag(early_tone_flag), .carrier_present_n(carrier_present_n),
		.handsetInputSelect(handsetInputSelect), .powerDown(powerDown));
	mcu_reader_model mcu_reader_model_inst (.dataIn(dataOut),
		.pinFromDevice(shift_clock_pin_out), .pinEnable(shift_clock_pin_oe),
		.pinLevel(shift_clock_pin_in));
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			$display("ERROR %0t: timeout", $time);
			close_out();
		end
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#2;
	endtask
	task automatic setCtrl(input logic i, input logic a, input logic b);
		iface_select = i;
		function_select_a = a;
		function_select_b = b;
		tick(4);
	endtask
	// one demodulated bit; strobes spaced wider than the mid-bit pulse
	task automatic sendBit(input logic b, input logic chk, input int tail);
		demodBit = b;
		bitMidStrobe = 1'h1;
		tick(1);
		bitMidStrobe = 1'h0;
		tick(1);
		if (chk)
		begin
			check(dataOut, b);
			check(shift_clock_pin_out, 1'h1);
		end
		tick(tail);
	endtask
	task automatic sendWord(input logic [7:0] data, input logic stop, input logic chk);
		sendBit(START_LEVEL, chk, 98);
		for (int i = 0; i < 8; i++)
			sendBit(data[i], chk, 98);
		sendBit(stop, chk, 0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		tick(10);
		check(dataOut, 1'h1);
		check(ready_or_steering_n, 1'h1);
		check(carrier_present_n, 1'h1);
		check(early_tone_flag, 1'h0);
		tick(10);
		rst_n = 1'h1;
		tick(4);
		// function selection and power down
		setCtrl(1'h0, 1'h1, 1'h0);
		check(handsetInputSelect, 1'h1);
		setCtrl(1'h0, 1'h0, 1'h1);
		check(handsetInputSelect, 1'h0);
		check(powerDown, 1'h0);
		setCtrl(1'h1, 1'h0, 1'h0);
		check(powerDown, 1'h1);
		// alert tone steering on the handset input
		setCtrl(1'h0, 1'h1, 1'h0);
		check(powerDown, 1'h0);
		toneRaw = 1'h1;
		tick(2);
		check(early_tone_flag, 1'h1);
		guard_time_node = 1'h1;
		tick(4);
		check(ready_or_steering_n, 1'h0);
		guard_time_node = 1'h0;
		tick(4);
		check(ready_or_steering_n, 1'h1);
		toneRaw = 1'h0;
		tick(2);
		check(early_tone_flag, 1'h0);
		// mode 0: no carrier means no data
		setCtrl(1'h0, 1'h1, 1'h1);
		check(shift_clock_pin_oe, 1'h1);
		check(handsetInputSelect, 1'h0);
		sendWord(8'h00, 1'h0, 1'h0);
		check(dataOut, 1'h1);
		check(ready_or_steering_n, 1'h1);
		carrierRaw = 1'h1;
		tick(2);
		check(carrier_present_n, 1'h0);
		sendWord(8'h3C, 1'h1, 1'h1);
		check(ready_or_steering_n, 1'h0);
		for (n = 0; n < 60 && ready_or_steering_n === 1'h0; n++)
			tick(1);
		check(n >= HALF - 2 && n <= HALF, 1'h1);
		tick(100);
		// brief dropout keeps carrier, a long one clears it
		carrierRaw = 1'h0;
		tick(HOLD - 10);
		check(carrier_present_n, 1'h0);
		tick(20);
		check(carrier_present_n, 1'h1);
		carrierRaw = 1'h1;
		tick(2);
		// mode 1: buffered byte read by shift pulses
		setCtrl(1'h1, 1'h1, 1'h1);
		check(shift_clock_pin_oe, 1'h0);
		sendWord(8'hA5, 1'h1, 1'h0);
		for (n = 0; n < 20 && ready_or_steering_n !== 1'h0; n++)
			tick(1);
		check(ready_or_steering_n, 1'h0);
		fork
			mcu_reader_model_inst.readWord(word);
			begin
				tick(10);
				check(ready_or_steering_n, 1'h1);
			end
		join
		check(word, {1'h1, 8'hA5});
		tick(20);
		// two words queue up while the controller stalls
		sendWord(8'hC3, 1'h1, 1'h0);
		tick(100);
		sendWord(8'h5A, 1'h0, 1'h0);
		tick(100);
		mcu_reader_model_inst.readWord(word);
		check(word, {1'h1, 8'hC3});
		mcu_reader_model_inst.readWord(word);
		check(word, {1'h0, 8'h5A});
		tick(10);
		close_out();
	end
endmodule // tb
`default_nettype wire
